//--- shared/dbsp_map.svh
// Constants for the two-word burst memory port
`ifndef DBSP_MAP_SVH
`define DBSP_MAP_SVH
`define DBSP_DW 36
`define DBSP_BW 4
`define DBSP_LANE 9
`define DBSP_AW 10
`define DBSP_DEPTH 1024
`define DBSP_BURST 2
`define DBSP_RD_LAT 5
`define DBSP_RD_LAT_DLL_OFF 2
`define DBSP_SLOW_MHZ 167
`endif

//--- shared/dbsp_pkg.sv
// Types for the two-word burst memory port
`include "dbsp_map.svh"
package dbsp_pkg;
   typedef logic [`DBSP_DW-1:0] dbsp_word_t;
   typedef logic [`DBSP_BW-1:0] dbsp_bsel_t;
   typedef logic [`DBSP_AW-2:0] dbsp_addr_t;
   typedef enum logic [1:0] {
      DBSP_IDLE = 2'b00,
      DBSP_WR0  = 2'b01,
      DBSP_WR1  = 2'b11
   } dbsp_wst_t;
endpackage

//--- shared/dbsp_if.sv
// Link between memory controller and burst memory
`timescale 1ns/100ps
interface dbsp_if;
   logic load_strobe_n;
   logic rd_wr;
   dbsp_pkg::dbsp_addr_t addr;
   dbsp_pkg::dbsp_bsel_t byte_write_sel_n;
   dbsp_pkg::dbsp_word_t ctl_dq_o;
   logic ctl_dq_oe_n;
   dbsp_pkg::dbsp_word_t mem_dq_o;
   logic mem_dq_oe_n;
   logic out_valid_flag;
   logic echo_clock;
   logic pll_off_n;
   dbsp_pkg::dbsp_word_t dq;
   assign dq = !mem_dq_oe_n ? mem_dq_o : ctl_dq_o;
   modport mem (input load_strobe_n, rd_wr, addr, byte_write_sel_n, dq, pll_off_n,
      output mem_dq_o, mem_dq_oe_n, out_valid_flag, echo_clock);
   modport ctl (output load_strobe_n, rd_wr, addr, byte_write_sel_n, ctl_dq_o,
      ctl_dq_oe_n, pll_off_n, input dq, out_valid_flag, echo_clock);
endinterface

//--- logic/dbsp_mem.sv
// Memory end: burst-of-two store with shared data pins
//
// Operation
// R01: Write words captured on both half-cycles
// R02: Read words driven on both half-cycles
// R03: Data pins released when not reading
// R04: Low load strobe starts a cycle
// R05: Every access moves exactly two words; reads loaded on back-to-back cycles drive three words here
// R06: Byte selects sampled with their word
// R07: Deselected byte keeps stored value
// R08: One select per nine-bit lane
// R09: Data bus 36 bits, shared pins
// R10: Address sampled when access loaded
// R11: Storage split into two arrays
// R12: Controller may permute address bits
// R13: Direction high reads, low writes
// R14: Accesses begin on the rising edge
// R15: Valid flag marks driven read data
// R16: Read and write addresses alternate edges
// R17: Pll off gives one-cycle latency
// R18: Read data appears after latency delay
// R19: Write data follows the command cycle
`timescale 1ns/100ps
`include "dbsp_map.svh"
module dbsp_mem (
   input wire logic clk,
   input wire logic rst_b,
   dbsp_if.mem lnk
);
   // ------------------------------------------
   // Storage
   // ------------------------------------------
   // R11: two arrays
   dbsp_pkg::dbsp_word_t arr0 [0:`DBSP_DEPTH/2-1];
   dbsp_pkg::dbsp_word_t arr1 [0:`DBSP_DEPTH/2-1];
   // No reset: contents survive rst_b

   // ------------------------------------------
   // Command decode
   // ------------------------------------------
   // Half-cycles are modelled as one clk each: phase 0 is the positive edge,
   // phase 1 the complementary edge.
   dbsp_pkg::dbsp_wst_t wst_ff, nxt_wst;
   dbsp_pkg::dbsp_addr_t waddr_ff, nxt_waddr;
   dbsp_pkg::dbsp_addr_t raddr_ff, nxt_raddr;
   logic [`DBSP_RD_LAT-1:0] rpipe_ff, nxt_rpipe;
   logic rword_ff, nxt_rword;
   dbsp_pkg::dbsp_word_t q_ff, nxt_q;
   logic q_oe_n_ff, nxt_q_oe_n;
   logic echo_ff, nxt_echo;
   logic ld_rd, ld_wr;
   logic rd_launch;
   dbsp_pkg::dbsp_word_t wr_mask;
   dbsp_pkg::dbsp_word_t nxt_cell0, nxt_cell1;
   logic wen0, wen1;

   // R04: strobe sampled
   // R13: direction selects access
   // R14: accesses start on rising edge
   assign ld_rd = !lnk.load_strobe_n && lnk.rd_wr;
   // Write refused while a burst lands
   assign ld_wr = !lnk.load_strobe_n && !lnk.rd_wr && (wst_ff == dbsp_pkg::DBSP_IDLE);

   // ------------------------------------------
   // Lane masks
   // ------------------------------------------
   // R06: select per lane
   // R08: nine-bit lanes
   // Select low writes the lane
   genvar g;
   generate
      for (g = 0; g < `DBSP_BW; g++) begin : g_lane
         assign wr_mask[g*`DBSP_LANE +: `DBSP_LANE] = {`DBSP_LANE{!lnk.byte_write_sel_n[g]}};
      end
   endgenerate

   // ------------------------------------------
   // Write sequencing
   // ------------------------------------------
   always_comb begin
      nxt_wst = wst_ff;
      nxt_waddr = waddr_ff;
      case (wst_ff)
         dbsp_pkg::DBSP_IDLE: begin
            // R10: address sampled
            if (ld_wr) begin
               nxt_waddr = lnk.addr;
               nxt_wst = dbsp_pkg::DBSP_WR0;
            end
         end
         // R19: data follows command
         dbsp_pkg::DBSP_WR0: nxt_wst = dbsp_pkg::DBSP_WR1;
         // R05: two words
         dbsp_pkg::DBSP_WR1: nxt_wst = dbsp_pkg::DBSP_IDLE;
         default: nxt_wst = dbsp_pkg::DBSP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wst_ff <= dbsp_pkg::DBSP_IDLE;
         waddr_ff <= '0;
      end else begin
         wst_ff <= nxt_wst;
         waddr_ff <= nxt_waddr;
      end
   end

   // ------------------------------------------
   // Storage write
   // ------------------------------------------
   // R01: capture each word
   // R07: masked bytes unchanged
   always_comb begin
      wen0 = (wst_ff == dbsp_pkg::DBSP_WR0);
      wen1 = (wst_ff == dbsp_pkg::DBSP_WR1);
      nxt_cell0 = (arr0[waddr_ff] & ~wr_mask) | (lnk.dq & wr_mask);
      nxt_cell1 = (arr1[waddr_ff] & ~wr_mask) | (lnk.dq & wr_mask);
   end

   always_ff @(posedge clk) begin
      if (wen0) begin
         arr0[waddr_ff] <= nxt_cell0;
      end
      if (wen1) begin
         arr1[waddr_ff] <= nxt_cell1;
      end
   end

   // ------------------------------------------
   // Read pipeline
   // ------------------------------------------
   always_comb begin
      nxt_rpipe = {rpipe_ff[`DBSP_RD_LAT-2:0], ld_rd};
      // R16: read address held apart
      nxt_raddr = ld_rd ? lnk.addr : raddr_ff;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rpipe_ff <= '0;
         raddr_ff <= '0;
      end else begin
         rpipe_ff <= nxt_rpipe;
         raddr_ff <= nxt_raddr;
      end
   end

   // ------------------------------------------
   // Read output
   // ------------------------------------------
   // R17: latency by pll mode
   // R18: read latency
   // Tap counts half-cycles from the command edge
   assign rd_launch = lnk.pll_off_n ? rpipe_ff[`DBSP_RD_LAT-1] :
      rpipe_ff[`DBSP_RD_LAT_DLL_OFF-1];

   always_comb begin
      nxt_rword = 1'b0;
      nxt_q = q_ff;
      nxt_q_oe_n = 1'b1;
      if (rd_launch) begin
         // R02: first word
         nxt_q = arr0[raddr_ff];
         nxt_q_oe_n = 1'b0;
         nxt_rword = 1'b1;
      end else if (rword_ff) begin
         // R05: second word
         nxt_q = arr1[raddr_ff];
         nxt_q_oe_n = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rword_ff <= 1'b0;
         q_ff <= '0;
         q_oe_n_ff <= 1'b1;
      end else begin
         rword_ff <= nxt_rword;
         q_ff <= nxt_q;
         q_oe_n_ff <= nxt_q_oe_n;
      end
   end

   // ------------------------------------------
   // Echo clock
   // ------------------------------------------
   // Free-running, one toggle per half-cycle
   always_comb begin
      nxt_echo = !echo_ff;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         echo_ff <= 1'b0;
      end else begin
         echo_ff <= nxt_echo;
      end
   end

   // ------------------------------------------
   // Outputs
   // ------------------------------------------
   // R09: 36-bit shared pins
   assign lnk.mem_dq_o = q_ff;
   // R03: released unless reading
   assign lnk.mem_dq_oe_n = q_oe_n_ff;
   // R15: valid with data
   assign lnk.out_valid_flag = !q_oe_n_ff;
   assign lnk.echo_clock = echo_ff;
endmodule

//--- logic/dbsp_ctl.sv
// Controller end: issues two-word burst accesses
`timescale 1ns/100ps
`include "dbsp_map.svh"
module dbsp_ctl (
   input wire logic clk,
   input wire logic rst_b,
   dbsp_if.ctl lnk,
   input wire logic req_valid,
   input wire logic req_rd,
   input wire dbsp_pkg::dbsp_addr_t req_addr,
   input wire dbsp_pkg::dbsp_word_t req_wd0,
   input wire dbsp_pkg::dbsp_word_t req_wd1,
   input wire dbsp_pkg::dbsp_bsel_t req_bsel0_n,
   input wire dbsp_pkg::dbsp_bsel_t req_bsel1_n,
   input wire logic pll_off_n,
   output logic req_ready,
   output dbsp_pkg::dbsp_word_t rd_data,
   output logic rd_valid
);
   // ------------------------------------------
   // Command sequencing
   // ------------------------------------------
   dbsp_pkg::dbsp_wst_t st_ff, nxt_st;
   logic ld_n_ff, nxt_ld_n;
   logic rw_ff, nxt_rw;
   dbsp_pkg::dbsp_addr_t a_ff, nxt_a;
   dbsp_pkg::dbsp_word_t w0_ff, nxt_w0, w1_ff, nxt_w1, d_ff, nxt_d;
   dbsp_pkg::dbsp_bsel_t b0_ff, nxt_b0, b1_ff, nxt_b1, bs_ff, nxt_bs;
   logic oe_n_ff, nxt_oe_n;
   dbsp_pkg::dbsp_word_t rd_ff, nxt_rd;
   logic rv_ff, nxt_rv;

   assign req_ready = (st_ff == dbsp_pkg::DBSP_IDLE);

   always_comb begin
      nxt_st = st_ff;
      nxt_ld_n = 1'b1;
      nxt_rw = 1'b1;
      nxt_a = a_ff;
      nxt_w0 = w0_ff;
      nxt_w1 = w1_ff;
      nxt_b0 = b0_ff;
      nxt_b1 = b1_ff;
      nxt_d = d_ff;
      nxt_bs = 4'hF;
      nxt_oe_n = 1'b1;
      nxt_rd = lnk.out_valid_flag ? lnk.dq : rd_ff;
      nxt_rv = lnk.out_valid_flag;
      case (st_ff)
         dbsp_pkg::DBSP_IDLE: begin
            // R04: strobe low starts cycle
            // R12: any address order works
            if (req_valid) begin
               nxt_ld_n = 1'b0;
               // R13: direction
               nxt_rw = req_rd;
               nxt_a = req_addr;
               nxt_w0 = req_wd0;
               nxt_w1 = req_wd1;
               nxt_b0 = req_bsel0_n;
               nxt_b1 = req_bsel1_n;
               if (!req_rd) begin
                  nxt_st = dbsp_pkg::DBSP_WR0;
               end
            end
         end
         dbsp_pkg::DBSP_WR0: begin
            // R19: first word after command
            // R06: selects with data
            nxt_d = w0_ff;
            nxt_bs = b0_ff;
            nxt_oe_n = 1'b0;
            nxt_st = dbsp_pkg::DBSP_WR1;
         end
         dbsp_pkg::DBSP_WR1: begin
            // R05: second word
            nxt_d = w1_ff;
            nxt_bs = b1_ff;
            nxt_oe_n = 1'b0;
            nxt_st = dbsp_pkg::DBSP_IDLE;
         end
         default: nxt_st = dbsp_pkg::DBSP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff <= dbsp_pkg::DBSP_IDLE;
         ld_n_ff <= 1'b1;
         rw_ff <= 1'b1;
         a_ff <= '0;
         w0_ff <= '0;
         w1_ff <= '0;
         b0_ff <= 4'hF;
         b1_ff <= 4'hF;
         d_ff <= '0;
         bs_ff <= 4'hF;
         oe_n_ff <= 1'b1;
         rd_ff <= '0;
         rv_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         ld_n_ff <= nxt_ld_n;
         rw_ff <= nxt_rw;
         a_ff <= nxt_a;
         w0_ff <= nxt_w0;
         w1_ff <= nxt_w1;
         b0_ff <= nxt_b0;
         b1_ff <= nxt_b1;
         d_ff <= nxt_d;
         bs_ff <= nxt_bs;
         oe_n_ff <= nxt_oe_n;
         rd_ff <= nxt_rd;
         rv_ff <= nxt_rv;
      end
   end

   // Write cycle (state WR0) leaves the command pins already loaded one clk
   // earlier, so ld_n_ff marks the command and data trails it.
   assign lnk.load_strobe_n = ld_n_ff;
   assign lnk.rd_wr = rw_ff;
   assign lnk.addr = a_ff;
   assign lnk.byte_write_sel_n = bs_ff;
   assign lnk.ctl_dq_o = d_ff;
   assign lnk.ctl_dq_oe_n = oe_n_ff;
   assign lnk.pll_off_n = pll_off_n;
   assign rd_data = rd_ff;
   assign rd_valid = rv_ff;
endmodule

//--- verif/dbsp_chk_sva.sv
// Assertions on the controller to memory link
`timescale 1ns/100ps
module dbsp_chk (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic load_strobe_n,
   input wire logic rd_wr,
   input wire dbsp_pkg::dbsp_bsel_t byte_write_sel_n,
   input wire logic ctl_dq_oe_n,
   input wire logic mem_dq_oe_n,
   input wire logic out_valid_flag,
   input wire logic echo_clock,
   input wire logic pll_off_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_rd_long;
      !load_strobe_n && rd_wr && pll_off_n |-> ##6 !mem_dq_oe_n [*2] ##1 mem_dq_oe_n;
   endproperty
   a_rd_long: assert property (p_rd_long) else $error("slow read timing");
   property p_rd_short;
      !load_strobe_n && rd_wr && !pll_off_n |-> ##3 !mem_dq_oe_n [*2] ##1 mem_dq_oe_n;
   endproperty
   a_rd_short: assert property (p_rd_short) else $error("short read timing");
   property p_vld_drv;
      out_valid_flag == !mem_dq_oe_n && (mem_dq_oe_n || ctl_dq_oe_n);
   endproperty
   a_vld_drv: assert property (p_vld_drv) else $error("valid flag off drive");
   property p_vld_len;
      $rose(out_valid_flag) |-> out_valid_flag [*2] ##1 !out_valid_flag;
   endproperty
   a_vld_len: assert property (p_vld_len) else $error("read not two words");
   property p_wr_quiet;
      !load_strobe_n && !rd_wr |-> mem_dq_oe_n [*3];
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("memory drives in write");
   property p_wr_data;
      !load_strobe_n && !rd_wr |-> ##1 (!ctl_dq_oe_n && load_strobe_n) [*2] ##1 ctl_dq_oe_n;
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("write words misplaced");
   property p_sel_idle;
      ctl_dq_oe_n |-> byte_write_sel_n == 4'hF;
   endproperty
   a_sel_idle: assert property (p_sel_idle) else $error("select outside write");
   property p_echo;
      $past(rst_b) |-> echo_clock != $past(echo_clock);
   endproperty
   a_echo: assert property (p_echo) else $error("echo clock stuck");
   c_rd_long: cover property (!load_strobe_n && rd_wr && pll_off_n);
   c_rd_short: cover property (!load_strobe_n && rd_wr && !pll_off_n);
   c_wr_part: cover property (!load_strobe_n && !rd_wr ##1 byte_write_sel_n != 4'h0);
endmodule

//--- verif/tb_ddr_burst2_sram_port.sv
// Self-checking bench for the burst memory port
`timescale 1ns/100ps
`include "dbsp_map.svh"
module tb_ddr_burst2_sram_port;
   logic clk, rst_b, req_valid, req_rd, pll_off_n, req_ready, rd_valid;
   dbsp_pkg::dbsp_addr_t req_addr;
   dbsp_pkg::dbsp_word_t req_wd0, req_wd1, rd_data;
   dbsp_pkg::dbsp_bsel_t req_bsel0_n, req_bsel1_n;
   dbsp_pkg::dbsp_word_t m0 [`DBSP_DEPTH/2];
   dbsp_pkg::dbsp_word_t m1 [`DBSP_DEPTH/2];
   dbsp_pkg::dbsp_addr_t pool [8];
   logic [31:0] seed, r;
   int fails, comparisons;
   dbsp_if lnk ();
   dbsp_mem dbsp_mem_i (.clk(clk), .rst_b(rst_b), .lnk(lnk));
   dbsp_ctl dbsp_ctl_i (.clk(clk), .rst_b(rst_b), .lnk(lnk), .req_valid(req_valid),
      .req_rd(req_rd), .req_addr(req_addr), .req_wd0(req_wd0), .req_wd1(req_wd1),
      .req_bsel0_n(req_bsel0_n), .req_bsel1_n(req_bsel1_n), .pll_off_n(pll_off_n),
      .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid));
   dbsp_chk dbsp_chk_i (.clk(clk), .rst_b(rst_b), .load_strobe_n(lnk.load_strobe_n),
      .rd_wr(lnk.rd_wr), .byte_write_sel_n(lnk.byte_write_sel_n),
      .ctl_dq_oe_n(lnk.ctl_dq_oe_n), .mem_dq_oe_n(lnk.mem_dq_oe_n),
      .out_valid_flag(lnk.out_valid_flag), .echo_clock(lnk.echo_clock),
      .pll_off_n(lnk.pll_off_n));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic dbsp_pkg::dbsp_word_t rword();
      logic [63:0] t;
      t = {rnd(), rnd()};
      return t[`DBSP_DW-1:0];
   endfunction
   function automatic dbsp_pkg::dbsp_word_t merge(input dbsp_pkg::dbsp_word_t o, n,
      input dbsp_pkg::dbsp_bsel_t s);
      for (int g = 0; g < `DBSP_BW; g++) begin
         if (s[g] == 1'b0) begin
            o[g*`DBSP_LANE +: `DBSP_LANE] = n[g*`DBSP_LANE +: `DBSP_LANE];
         end
      end
      return o;
   endfunction
   task automatic check(input dbsp_pkg::dbsp_word_t seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic op(input logic rd, input dbsp_pkg::dbsp_addr_t a,
      input dbsp_pkg::dbsp_bsel_t s0, s1);
      int t;
      int k;
      t = 0;
      k = 0;
      req_valid = 1'b1;
      req_rd = rd;
      req_addr = a;
      req_wd0 = rword();
      req_wd1 = rword();
      req_bsel0_n = s0;
      req_bsel1_n = s1;
      while (req_ready !== 1'b1 && t < 50) begin
         @(posedge clk);
         #1;
         t++;
      end
      check(dbsp_pkg::dbsp_word_t'(req_ready), 36'h1);
      @(posedge clk);
      #1 req_valid = 1'b0;
      if (!rd) begin
         m0[a] = merge(m0[a], req_wd0, s0);
         m1[a] = merge(m1[a], req_wd1, s1);
      end
      repeat (30) begin
         @(posedge clk);
         #1;
         if (rd_valid === 1'b1) begin
            check(rd_data, k == 0 ? m0[a] : m1[a]);
            k++;
         end
      end
      check(dbsp_pkg::dbsp_word_t'(k), rd ? 36'h2 : 36'h0);
      check(dbsp_pkg::dbsp_word_t'(lnk.mem_dq_oe_n), 36'h1);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #400000;
      fails++;
      tally_and_finish();
   end
   initial begin
      seed = 32'h06F1E18F;
      fails = 0;
      comparisons = 0;
      rst_b = 1'b0;
      req_valid = 1'b0;
      req_rd = 1'b0;
      req_addr = '0;
      req_wd0 = '0;
      req_wd1 = '0;
      req_bsel0_n = 4'hF;
      req_bsel1_n = 4'hF;
      pll_off_n = 1'b1;
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      for (int i = 0; i < 8; i++) begin
         pool[i] = (i == 0) ? 9'h000 : (i == 7) ? 9'h1FF : dbsp_pkg::dbsp_addr_t'(rnd());
         op(1'b0, pool[i], 4'h0, 4'h0);
      end
      op(1'b0, pool[7], 4'hF, 4'hF);
      op(1'b1, pool[7], 4'hF, 4'hF);
      op(1'b0, pool[0], 4'h5, 4'hA);
      op(1'b1, pool[0], 4'hF, 4'hF);
      for (int n = 0; n < 80; n++) begin
         r = rnd();
         pll_off_n = r[0];
         op(r[1], pool[r[4:2]], r[11:8], r[15:12]);
      end
      tally_and_finish();
   end
endmodule
